// file: common/atrcs_pkg.sv
// Purpose: Shared constants for the async retry and compare-swap block.
// Assumes: APB slave, 32-bit data, byte offsets as printed.
// Notes:   Resource reset values are the bus-management power-on values.
package atrcs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_UNITS = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] RETRY_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SWAP_DATA_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SWAP_CMP_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] SWAP_CTRL_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RETRY_STAT_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] FINAL_ACK_OFS = 8'h44;

  // Retry register fields (unit index 0 = request, 1 = response, 2 = phys)
  localparam int RETRY_FIELD_W = 4;
  localparam int REQ_LSB = 0;
  localparam int RESP_LSB = 4;
  localparam int PHYS_LSB = 8;
  localparam int RETRY_RW_W = 12;
  localparam logic [RETRY_RW_W-1:0] RETRY_RST = 12'h000;

  // Control register fields
  localparam int DONE_BIT = 31;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam logic DONE_RST = 1'b1;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

  // Status register fields
  localparam int STAT_UNIT_STRIDE = 8;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_SWAPPED_BIT = 31;

  typedef enum logic [SEL_W-1:0] {
    atrcs_bus_manager_id,
    atrcs_bandwidth_available,
    atrcs_channels_available_hi,
    atrcs_channels_available_lo
  } atrcs_res_t;

  localparam logic [3:0][DATA_W-1:0] RES_RST = {
    32'hffff_ffff, 32'hffff_ffff, 32'h0000_1333, 32'h0000_003f};

  // Acknowledge codes seen from the link
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_PENDING = 4'h2;
  localparam logic [3:0] ACK_BUSY_X = 4'h4;
  localparam logic [3:0] ACK_BUSY_A = 4'h5;
  localparam logic [3:0] ACK_BUSY_B = 4'h6;
  localparam logic [3:0] ACK_DATA_ERROR = 4'hd;

endpackage

// file: hw/atrcs_retry_unit.sv
// Purpose: Retry bookkeeping for one asynchronous transmit unit.
// Assumes: Link logic on pclk, one ack_valid per packet attempt.
// Notes:   Limit is latched at packet start.
`timescale 1ns/1ps
module atrcs_retry_unit #(
  parameter int CNT_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [CNT_W-1:0] limit,
  input wire logic pkt_start,
  input wire logic ack_valid,
  input wire logic [3:0] ack_code,
  output logic retry_pulse,
  output logic done_pulse,
  output logic [3:0] final_ack,
  output logic [CNT_W-1:0] attempts,
  output logic busy
);
  import atrcs_pkg::*;

  if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end

  typedef enum logic {ru_idle, ru_wait} atrcs_ru_state_t;

  atrcs_ru_state_t state_reg;
  logic [CNT_W-1:0] limit_reg;
  logic [CNT_W-1:0] attempts_reg;
  logic retryable;
  logic do_retry;
  logic do_finish;

  assign retryable = (ack_code == ACK_BUSY_X) || (ack_code == ACK_BUSY_A) ||
                     (ack_code == ACK_BUSY_B) || (ack_code == ACK_DATA_ERROR);
  assign do_retry = (state_reg == ru_wait) && ack_valid && retryable &&
                    (attempts_reg < limit_reg);
  assign do_finish = (state_reg == ru_wait) && ack_valid && !do_retry;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ru_idle;
    end else if (pkt_start) begin
      state_reg <= ru_wait;
    end else if (do_finish) begin
      state_reg <= ru_idle;
    end
  end

  // Latched so a limit rewrite mid-packet cannot strand a packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_reg <= '0;
      attempts_reg <= '0;
    end else if (pkt_start) begin
      limit_reg <= limit;
      attempts_reg <= '0;
    end else if (do_retry) begin
      attempts_reg <= attempts_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_pulse <= 1'b0;
      done_pulse <= 1'b0;
      final_ack <= 4'h0;
    end else begin
      retry_pulse <= do_retry && !pkt_start;
      done_pulse <= do_finish && !pkt_start;
      if (do_finish && !pkt_start) begin
        final_ack <= ack_code;
      end
    end
  end

  assign attempts = attempts_reg;
  assign busy = (state_reg == ru_wait);

endmodule // atrcs_retry_unit

// file: hw/atrcs_swap_engine.sv
// Purpose: Holds the four bus-management resources and swaps atomically.
// Assumes: One start pulse at a time; result one cycle later.
// Notes:   Single-cycle read-compare-write, so no other access can slip in.
`timescale 1ns/1ps
module atrcs_swap_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire atrcs_pkg::atrcs_res_t sel,
  input wire logic [atrcs_pkg::DATA_W-1:0] compare_val,
  input wire logic [atrcs_pkg::DATA_W-1:0] data_val,
  output logic done_pulse,
  output logic swapped,
  output logic [atrcs_pkg::DATA_W-1:0] old_value
);
  import atrcs_pkg::*;

  logic [DATA_W-1:0] res_mem [4];
  logic hit;

  assign hit = (res_mem[sel] == compare_val);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        res_mem[i] <= RES_RST[i];
      end
    end else if (start && hit) begin
      res_mem[sel] <= data_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pulse <= 1'b0;
      swapped <= 1'b0;
      old_value <= '0;
    end else begin
      done_pulse <= start;
      if (start) begin
        swapped <= hit;
        old_value <= res_mem[sel];
      end
    end
  end

endmodule // atrcs_swap_engine

// file: hw/atrcs_top.sv
// Purpose: APB register bank for async transmit retry limits and the
//          compare-swap access to the bus-management resources.
// Assumes: APB4 master on pclk; link-side ack inputs on pclk.
// Notes:   Zero-wait access phase; read data captured in the setup cycle.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module atrcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [atrcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [atrcs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [atrcs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [atrcs_pkg::NUM_UNITS-1:0] pkt_start,
  input wire logic [atrcs_pkg::NUM_UNITS-1:0] ack_valid,
  input wire logic [3:0] req_ack_code,
  input wire logic [3:0] resp_ack_code,
  input wire logic [3:0] phys_ack_code,
  output logic [atrcs_pkg::NUM_UNITS-1:0] retry_pulse,
  output logic [atrcs_pkg::NUM_UNITS-1:0] done_pulse,
  output logic [3:0] req_final_ack,
  output logic [3:0] resp_final_ack,
  output logic [3:0] phys_final_ack,
  output logic swap_complete_flag
);
  import atrcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register state

  logic [RETRY_RW_W-1:0] retry_limits_reg;
  logic [DATA_W-1:0] swap_data_operand_reg;
  logic [DATA_W-1:0] swap_compare_operand_reg;
  atrcs_res_t swap_resource_select_reg;
  logic swap_complete_flag_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;

  logic setup_phase;
  logic wr_access;
  logic addr_mapped;
  logic [DATA_W-1:0] rd_next;
  logic [DATA_W-1:0] wmask;

  logic swap_start;
  logic swap_done;
  logic swap_hit;
  logic [DATA_W-1:0] swap_old;

  logic [3:0] ack_code [NUM_UNITS];
  logic [3:0] final_ack [NUM_UNITS];
  logic [RETRY_FIELD_W-1:0] attempts [NUM_UNITS];
  logic [NUM_UNITS-1:0] unit_busy;
  logic [DATA_W-1:0] retry_stat;
  logic [DATA_W-1:0] final_ack_word;

  logic [RETRY_FIELD_W-1:0] phys_response_retry_count;
  logic [RETRY_FIELD_W-1:0] tx_response_retry_count;
  logic [RETRY_FIELD_W-1:0] tx_request_retry_count;
  logic [RETRY_FIELD_W-1:0] unit_limit [NUM_UNITS];
  logic [DATA_W-1:0] retry_word;
  logic [DATA_W-1:0] control_word;

  //////////////////////////////////////////////////////////////////////////
  // APB handshake

  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{pstrb[b]}};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb begin
    if (paddr == RETRY_OFS) begin
      addr_mapped = 1'b1;
    end else if (paddr == SWAP_DATA_OFS) begin
      addr_mapped = 1'b1;
    end else if (paddr == SWAP_CMP_OFS) begin
      addr_mapped = 1'b1;
    end else if (paddr == SWAP_CTRL_OFS) begin
      addr_mapped = 1'b1;
    end else if (paddr == RETRY_STAT_OFS) begin
      addr_mapped = 1'b1;
    end else if (paddr == FINAL_ACK_OFS) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux, captured at the setup edge

  always_comb begin
    rd_next = '0;
    if (paddr == RETRY_OFS) begin
      rd_next = retry_word;
    end else if (paddr == SWAP_DATA_OFS) begin
      rd_next = swap_data_operand_reg;
    end else if (paddr == SWAP_CMP_OFS) begin
      rd_next = swap_compare_operand_reg;
    end else if (paddr == SWAP_CTRL_OFS) begin
      rd_next = control_word;
    end else if (paddr == RETRY_STAT_OFS) begin
      rd_next = retry_stat;
    end else if (paddr == FINAL_ACK_OFS) begin
      rd_next = final_ack_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? '0 : rd_next;
      pslverr_reg <= !addr_mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Retry limits register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_limits_reg <= RETRY_RST;
    end else if (wr_access && paddr == RETRY_OFS) begin
      retry_limits_reg <= (retry_limits_reg & ~wmask[RETRY_RW_W-1:0]) |
                          (pwdata[RETRY_RW_W-1:0] & wmask[RETRY_RW_W-1:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register views

  assign phys_response_retry_count =
    retry_limits_reg[PHYS_LSB +: RETRY_FIELD_W];
  assign tx_response_retry_count =
    retry_limits_reg[RESP_LSB +: RETRY_FIELD_W];
  assign tx_request_retry_count =
    retry_limits_reg[REQ_LSB +: RETRY_FIELD_W];

  // Upper twenty bits stay zero: no dual-phase retry
  always_comb begin
    retry_word = '0;
    retry_word[PHYS_LSB +: RETRY_FIELD_W] = phys_response_retry_count;
    retry_word[RESP_LSB +: RETRY_FIELD_W] = tx_response_retry_count;
    retry_word[REQ_LSB +: RETRY_FIELD_W] = tx_request_retry_count;
  end

  always_comb begin
    control_word = '0;
    control_word[DONE_BIT] = swap_complete_flag_reg;
    control_word[SEL_LSB +: SEL_W] = swap_resource_select_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare-swap operands and control

  // Operands are host-loaded; after a swap the data operand returns
  // the resource's prior value so software can see what it replaced.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_data_operand_reg <= '0;
    end else if (swap_done) begin
      swap_data_operand_reg <= swap_old;
    end else if (wr_access && paddr == SWAP_DATA_OFS) begin
      swap_data_operand_reg <= (swap_data_operand_reg & ~wmask) |
                               (pwdata & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_compare_operand_reg <= '0;
    end else if (wr_access && paddr == SWAP_CMP_OFS) begin
      swap_compare_operand_reg <= (swap_compare_operand_reg & ~wmask) |
                                  (pwdata & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_resource_select_reg <= atrcs_res_t'(SEL_RST);
    end else if (wr_access && paddr == SWAP_CTRL_OFS && pstrb[0]) begin
      swap_resource_select_reg <=
        atrcs_res_t'(pwdata[SEL_LSB +: SEL_W]);
    end
  end

  // Any control write starts a swap, whatever the byte strobes
  assign swap_start = wr_access && (paddr == SWAP_CTRL_OFS);

  // Completion set wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_complete_flag_reg <= DONE_RST;
    end else if (swap_done) begin
      swap_complete_flag_reg <= 1'b1;
    end else if (swap_start) begin
      swap_complete_flag_reg <= 1'b0;
    end
  end

  assign swap_complete_flag = swap_complete_flag_reg;

  // Selector takes effect on the same edge as the start
  atrcs_swap_engine u_swap (
    .pclk(pclk),
    .presetn(presetn),
    .start(swap_start),
    .sel(atrcs_res_t'(pstrb[0] ? pwdata[SEL_LSB +: SEL_W]
                               : swap_resource_select_reg)),
    .compare_val(swap_compare_operand_reg),
    .data_val(swap_data_operand_reg),
    .done_pulse(swap_done),
    .swapped(swap_hit),
    .old_value(swap_old)
  );

  //////////////////////////////////////////////////////////////////////////
  // Retry units

  assign ack_code[0] = req_ack_code;
  assign ack_code[1] = resp_ack_code;
  assign ack_code[2] = phys_ack_code;

  assign unit_limit[0] = tx_request_retry_count;
  assign unit_limit[1] = tx_response_retry_count;
  assign unit_limit[2] = phys_response_retry_count;

  generate
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      // Exhausted units stop and report the last acknowledge
      atrcs_retry_unit #(
        .CNT_W(RETRY_FIELD_W)
      ) u_retry (
        .pclk(pclk),
        .presetn(presetn),
        .limit(unit_limit[u]),
        .pkt_start(pkt_start[u]),
        .ack_valid(ack_valid[u]),
        .ack_code(ack_code[u]),
        .retry_pulse(retry_pulse[u]),
        .done_pulse(done_pulse[u]),
        .final_ack(final_ack[u]),
        .attempts(attempts[u]),
        .busy(unit_busy[u])
      );
    end
  endgenerate

  assign req_final_ack = final_ack[0];
  assign resp_final_ack = final_ack[1];
  assign phys_final_ack = final_ack[2];

  //////////////////////////////////////////////////////////////////////////
  // Status words

  always_comb begin
    retry_stat = '0;
    final_ack_word = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      retry_stat[u*STAT_UNIT_STRIDE +: RETRY_FIELD_W] = attempts[u];
      retry_stat[u*STAT_UNIT_STRIDE + STAT_BUSY_BIT] = unit_busy[u];
      final_ack_word[4*u +: 4] = final_ack[u];
    end
    retry_stat[STAT_SWAPPED_BIT] = swap_hit;
  end

endmodule // atrcs_top

// file: tb/atrcs_assertions.sv
// Purpose: Port-level checks for the retry and compare-swap bank.
// Assumes: Single pclk domain, presetn asynchronous active low.
// Notes:   Bound onto every atrcs_top instance.
`timescale 1ns/1ps
module atrcs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [atrcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [atrcs_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [atrcs_pkg::NUM_UNITS-1:0] ack_valid,
  input wire logic [3:0] req_ack_code,
  input wire logic [3:0] resp_ack_code,
  input wire logic [3:0] phys_ack_code,
  input wire logic [atrcs_pkg::NUM_UNITS-1:0] retry_pulse,
  input wire logic [atrcs_pkg::NUM_UNITS-1:0] done_pulse,
  input wire logic [3:0] req_final_ack,
  input wire logic [3:0] resp_final_ack,
  input wire logic [3:0] phys_final_ack,
  input wire logic swap_complete_flag
);
  import atrcs_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd_retry;
  logic rd_ctrl;
  logic mapped;
  assign acc = psel && penable && pready;
  assign rd_retry = acc && !pwrite && paddr == RETRY_OFS;
  assign rd_ctrl = acc && !pwrite && paddr == SWAP_CTRL_OFS;
  assign mapped = paddr inside {RETRY_OFS, SWAP_DATA_OFS, SWAP_CMP_OFS,
    SWAP_CTRL_OFS, RETRY_STAT_OFS, FINAL_ACK_OFS};
  ////////////////////////////////////////////////////////////////////////
  sequence s_clear_set;
    !swap_complete_flag ##1 swap_complete_flag;
  endsequence
  property p_second_zero; rd_retry |-> prdata[31:29] == 3'h0; endproperty
  a_second_zero: assert property (p_second_zero)
    else $error("second limit not zero");
  property p_cycle_zero; rd_retry |-> prdata[28:16] == 13'h0; endproperty
  a_cycle_zero: assert property (p_cycle_zero)
    else $error("cycle limit not zero");
  property p_rsvd_zero; rd_retry |-> prdata[15:12] == 4'h0; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("retry reserved bits not zero");
  property p_ctrl_rsvd; rd_ctrl |-> prdata[30:2] == 29'h0; endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("control reserved bits not zero");
  property p_ctrl_done;
    rd_ctrl |-> prdata[31] == $past(swap_complete_flag);
  endproperty
  a_ctrl_done: assert property (p_ctrl_done)
    else $error("control bit 31 differs from flag");
  property p_clear_set;
    acc && pwrite && paddr == SWAP_CTRL_OFS |=> s_clear_set;
  endproperty
  a_clear_set: assert property (p_clear_set)
    else $error("flag not cleared then set after control write");
  property p_decode; acc |-> pslverr == !mapped; endproperty
  a_decode: assert property (p_decode)
    else $error("address decode error response wrong");
  property p_phys_final;
    done_pulse[2] |-> phys_final_ack == $past(phys_ack_code);
  endproperty
  a_phys_final: assert property (p_phys_final)
    else $error("phys final ack wrong");
  property p_resp_final;
    done_pulse[1] |-> resp_final_ack == $past(resp_ack_code);
  endproperty
  a_resp_final: assert property (p_resp_final)
    else $error("resp final ack wrong");
  property p_req_final;
    done_pulse[0] |-> req_final_ack == $past(req_ack_code);
  endproperty
  a_req_final: assert property (p_req_final)
    else $error("req final ack wrong");
  property p_answer;
    ((retry_pulse | done_pulse) & ~$past(ack_valid)) == 3'h0 &&
    (retry_pulse & done_pulse) == 3'h0;
  endproperty
  a_answer: assert property (p_answer)
    else $error("retry or done without one preceding ack");
endmodule // atrcs_chk

bind atrcs_top atrcs_chk atrcs_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ack_valid(ack_valid), .req_ack_code(req_ack_code),
  .resp_ack_code(resp_ack_code), .phys_ack_code(phys_ack_code),
  .retry_pulse(retry_pulse), .done_pulse(done_pulse),
  .req_final_ack(req_final_ack), .resp_final_ack(resp_final_ack),
  .phys_final_ack(phys_final_ack),
  .swap_complete_flag(swap_complete_flag));

// file: tb/atrcs_link_model.sv
// Purpose: Remote node model answering each transmit attempt.
// Assumes: One packet in flight at a time across all units.
// Notes:   Code lines carry a moving pattern outside ack cycles.
`timescale 1ns/1ps
module atrcs_link_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] pkt_start,
  input wire logic [2:0] retry_pulse,
  input wire logic [3:0] lag,
  input wire logic [3:0] busy_n,
  output logic [2:0] ack_valid,
  output logic [3:0] req_ack_code,
  output logic [3:0] resp_ack_code,
  output logic [3:0] phys_ack_code
);
  import atrcs_pkg::*;
  logic [3:0] tmr_reg [3];
  logic [3:0] k_reg [3];
  logic [3:0] pat_reg;
  // First busy_n answers are busy or data error, rotating codes
  function automatic logic [3:0] ack_for(input logic [3:0] k);
    if (k >= busy_n) return ACK_COMPLETE;
    case (k[1:0])
      2'h0: return ACK_BUSY_X;
      2'h1: return ACK_BUSY_A;
      2'h2: return ACK_BUSY_B;
      default: return ACK_DATA_ERROR;
    endcase
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_reg <= 4'h0;
      ack_valid <= 3'h0;
      for (int u = 0; u < 3; u++) begin
        tmr_reg[u] <= 4'h0;
        k_reg[u] <= 4'h0;
      end
    end else begin
      pat_reg <= pat_reg + 4'h5;
      for (int u = 0; u < 3; u++) begin
        ack_valid[u] <= tmr_reg[u] == 4'h1;
        if (pkt_start[u] || retry_pulse[u]) tmr_reg[u] <= lag;
        else if (tmr_reg[u] != 4'h0) tmr_reg[u] <= tmr_reg[u] - 4'h1;
        if (pkt_start[u]) k_reg[u] <= 4'h0;
        else if (ack_valid[u]) k_reg[u] <= k_reg[u] + 4'h1;
      end
    end
  end
  assign req_ack_code = ack_valid[0] ? ack_for(k_reg[0]) : pat_reg;
  assign resp_ack_code = ack_valid[1] ? ack_for(k_reg[1]) : ~pat_reg;
  assign phys_ack_code = ack_valid[2] ? ack_for(k_reg[2]) : pat_reg;
endmodule // atrcs_link_model

// file: tb/atrcs_top_tb.sv
// Purpose: Self-checking bench for the retry and compare-swap bank.
// Assumes: Zero-wait APB slave; link model answers each attempt.
// Notes:   Expected resource values come from the package reset table.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module atrcs_top_tb;
  import atrcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr;
  logic [2:0] pkt_start, ack_valid, retry_pulse, done_pulse;
  logic [3:0] rq_c, rs_c, ph_c, rq_f, rs_f, ph_f, lag, busy_n;
  int n_fail, n_checks, n_retry, cur_u;
  atrcs_top atrcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_start(pkt_start), .ack_valid(ack_valid), .req_ack_code(rq_c),
    .resp_ack_code(rs_c), .phys_ack_code(ph_c),
    .retry_pulse(retry_pulse), .done_pulse(done_pulse),
    .req_final_ack(rq_f), .resp_final_ack(rs_f), .phys_final_ack(ph_f),
    .swap_complete_flag(flag));
  atrcs_link_model atrcs_link_model_inst (.pclk(pclk), .presetn(presetn),
    .pkt_start(pkt_start), .retry_pulse(retry_pulse), .lag(lag),
    .busy_n(busy_n), .ack_valid(ack_valid), .req_ack_code(rq_c),
    .resp_ack_code(rs_c), .phys_ack_code(ph_c));
  always #25 pclk = ~pclk;
  always @(posedge pclk) n_retry += retry_pulse[cur_u];
  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // Operands first, then control, then poll completion
  task swap(input int s, input logic [31:0] cmp, dat, old);
    apb(1'b1, SWAP_CMP_OFS, cmp);
    apb(1'b1, SWAP_DATA_OFS, dat);
    apb(1'b1, SWAP_CTRL_OFS, 32'h7fff_fffc | s);
    @(negedge pclk);
    `CHK(flag, 1'b0)
    for (int i = 0; i < 20 && flag !== 1'b1; i++) @(posedge pclk);
    `CHK(flag, 1'b1)
    rd_chk(SWAP_CTRL_OFS, 32'h8000_0000 | s);
    rd_chk(SWAP_DATA_OFS, old);
  endtask
  task t_regs;
    rd_chk(RETRY_OFS, 32'h0);
    rd_chk(SWAP_CTRL_OFS, 32'h8000_0000);
    apb(1'b1, RETRY_OFS, 32'hffff_ffff);
    rd_chk(RETRY_OFS, 32'h0000_0fff);
    apb(1'b1, 8'h30, 32'h1);
    `CHK(rerr, 1'b1)
    rd_chk(8'h30, 32'h0);
    `CHK(rerr, 1'b1)
  endtask
  // Miss leaves the resource alone; last swap restores reset value
  task t_swap;
    logic [31:0] rv, nv;
    for (int s = 0; s < 4; s++) begin
      rv = RES_RST[s];
      nv = 32'h5a00_0000 + s;
      swap(s, rv, nv, rv);
      swap(s, ~nv, 32'h0, nv);
      swap(s, nv, rv, nv);
    end
  endtask
  function automatic logic [3:0] bcode(input int k);
    case (k % 4)
      0: return ACK_BUSY_X;
      1: return ACK_BUSY_A;
      2: return ACK_BUSY_B;
      default: return ACK_DATA_ERROR;
    endcase
  endfunction
  task run_pkt(input int u, lim, b, input logic [3:0] lg);
    logic [3:0] fin;
    cur_u = u;
    n_retry = 0;
    busy_n <= b; lag <= lg; pkt_start[u] <= 1'b1;
    @(posedge pclk);
    pkt_start <= 3'h0;
    for (int i = 0; i < 300 && done_pulse[u] !== 1'b1; i++) @(posedge pclk);
    `CHK(done_pulse[u], 1'b1)
    `CHK(n_retry, (b < lim) ? b : lim)
    fin = (u == 0) ? rq_f : (u == 1) ? rs_f : ph_f;
    `CHK(fin, (b > lim) ? bcode(lim) : ACK_COMPLETE)
    @(posedge pclk);
  endtask
  task t_units;
    apb(1'b1, RETRY_OFS, 32'h0000_0312);
    run_pkt(0, 2, 2, 4'h1);
    run_pkt(0, 2, 3, 4'h6);
    run_pkt(1, 1, 1, 4'h6);
    run_pkt(1, 1, 2, 4'h1);
    run_pkt(2, 3, 3, 4'h1);
    run_pkt(2, 3, 4, 4'h6);
    apb(1'b1, RETRY_OFS, 32'h0);
    run_pkt(0, 0, 1, 4'h2);
    rd_chk(FINAL_ACK_OFS,
      {20'h0, ACK_DATA_ERROR, ACK_BUSY_A, ACK_BUSY_X});
    // Attempts 0, 1, 3 per unit; last swap matched
    rd_chk(RETRY_STAT_OFS, 32'h8003_0100);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h0; pwdata = 32'h0; pkt_start = 3'h0; lag = 4'h1;
    busy_n = 4'h0; n_fail = 0; n_checks = 0; cur_u = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_swap;
    t_units;
    print_verdict;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #(20000 * 50);
    n_fail++;
    print_verdict;
  end
endmodule // atrcs_top_tb
